// >>> hdl/adc_ctrl_pkg.sv
/*
 * Constants, register map and helper decode for the converter control
 * block. Assumes a single 10 MHz module clock and word-indexed registers.
 */
//
// Overview of operation
// [RULE1] Average 2 to 64 consecutive same-input conversions
// [RULE2] Averaging factor zero passes every conversion
// [RULE3] One averaging setting shared by all sequencers
// [RULE4] One FIFO entry per complete averaged result
// [RULE5] Result rate is conversion rate over factor
// [RULE6] Clearing a sequencer drops its pending flag
// [RULE7] Interrupt holds until the clearing write lands
// [RULE8] Only enabled sources drive the interrupt output
// [RULE9] Twelve sources: done, DMA, compare per sequencer
// [RULE10] Enabling a source first discards its pending flag
// [RULE11] Raw and masked status readable per sequencer
// [RULE12] Module status read returns raw or masked view
// [RULE13] Sixteen-step read-back phase delay before start
// [RULE14] One phase delay shared by every sequencer
// [RULE15] Done flag set on last step, held till cleared
// [RULE16] Interrupt is OR of masked bits, next cycle
`default_nettype none

package adc_ctrl_pkg;

    localparam int DATA_W = 12;
    localparam int SEQ_N = 4;
    localparam int SEQ_W = 2;
    localparam int SRC_N = 12;
    localparam int ADDR_W = 4;
    localparam int SUM_W = 18;
    localparam int CNT_W = 6;
    localparam int CNT16_W = 16;

    // Register word indices
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_INT_ENABLE = 4'h1;
    localparam logic [3:0] REG_INT_STATUS = 4'h2;
    localparam logic [3:0] REG_INT_RAW = 4'h3;
    localparam logic [3:0] REG_INT_MASKED = 4'h4;
    localparam logic [3:0] REG_INT_CLEAR = 4'h5;
    localparam logic [3:0] REG_SEQ_STATUS = 4'h6;
    localparam logic [3:0] REG_RESULT_CNT0 = 4'h8;

    // Control field positions
    localparam int FACTOR_LSB = 0;
    localparam int FACTOR_W = 3;
    localparam int PHASE_LSB = 4;
    localparam int PHASE_W = 4;
    localparam int VIEW_BIT = 8;

    // Source bit groups
    localparam int DONE_LSB = 0;
    localparam int DMA_LSB = 4;
    localparam int CMP_LSB = 8;

    // Reset values
    localparam logic [FACTOR_W-1:0] FACTOR_RST = 3'h0;
    localparam logic [PHASE_W-1:0] PHASE_RST = 4'h0;
    localparam logic [SRC_N-1:0] ENABLE_RST = 12'h000;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_PERIOD_NS = 4000;
    localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PHASE_STEPS = 16;
    localparam int ACC_W = 10;
    localparam logic [2:0] MAX_SHIFT = 3'h6;

    // Averaging code to shift; codes above 6 act as 64x
    function automatic logic [2:0] avg_shift(input logic [2:0] code);
        avg_shift = (code > MAX_SHIFT) ? MAX_SHIFT : code;
    endfunction : avg_shift

endpackage : adc_ctrl_pkg

`default_nettype wire

// >>> hdl/sample_if.sv
/*
 * Conversion sample carrier between the control block's modules.
 * Assumes both ends on the same module clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface sample_if;
    import adc_ctrl_pkg::*;
    logic valid;
    logic [DATA_W-1:0] data;
    logic [SEQ_W-1:0] seq;
    logic last;
    modport src (output valid, output data, output seq, output last);
    modport dst (input valid, input data, input seq, input last);
endinterface : sample_if

`default_nettype wire

// >>> hdl/adc_averager.sv
/*
 * Hardware averager between the converter and the sequencer FIFOs.
 * Assumes the converter repeats each step for the programmed factor.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_averager (
    input wire logic clk, // Module clock
    input wire logic rst_n, // Sync reset, low
    input wire logic [adc_ctrl_pkg::FACTOR_W-1:0] factor, // Factor code
    sample_if.dst raw, // Raw conversions
    sample_if.src avg // Averaged results
);
    import adc_ctrl_pkg::*;

    logic [SUM_W-1:0] sum;
    logic [CNT_W-1:0] cnt;
    logic [2:0] shift;
    logic [SUM_W-1:0] total;
    logic [CNT_W-1:0] cnt_end;

    assign shift = avg_shift(factor); // [RULE3]
    assign total = sum + SUM_W'(raw.data);
    assign cnt_end = CNT_W'((7'h01 << shift) - 7'h01); // [RULE1]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sum <= '0;
            cnt <= '0;
            avg.valid <= 1'b0;
            avg.data <= '0;
            avg.seq <= '0;
            avg.last <= 1'b0;
        end else begin
            avg.valid <= 1'b0;
            if (raw.valid) begin
                if (shift == 3'h0) begin
                    avg.valid <= 1'b1; // [RULE2]
                    avg.data <= raw.data;
                    avg.seq <= raw.seq;
                    avg.last <= raw.last;
                end else if (cnt == cnt_end) begin
                    avg.valid <= 1'b1; // [RULE4] [RULE5]
                    avg.data <= DATA_W'(total >> shift);
                    avg.seq <= raw.seq;
                    avg.last <= raw.last;
                    sum <= '0;
                    cnt <= '0;
                end else begin
                    sum <= total;
                    cnt <= cnt + 6'h01;
                end
            end
        end
    end

endmodule : adc_averager

`default_nettype wire

// >>> hdl/adc_phase_delay.sv
/*
 * Shared trigger-to-start phase delay for all sequencers.
 * Assumes trigger inputs are one-cycle pulses on the module clock.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_phase_delay (
    input wire logic clk, // Module clock
    input wire logic rst_n, // Sync reset, low
    input wire logic [adc_ctrl_pkg::PHASE_W-1:0] phase, // Delay steps
    input wire logic [adc_ctrl_pkg::SEQ_N-1:0] trig, // Trigger pulses
    output logic [adc_ctrl_pkg::SEQ_N-1:0] start // Start pulses
);
    import adc_ctrl_pkg::*;

    logic [SEQ_N-1:0] pending;
    logic busy;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] target;
    logic [ACC_W-1:0] next_acc;

    // Elapsed time kept in sixteenths of a module clock cycle
    assign target = ACC_W'(phase * SAMPLE_CYC); // [RULE13]
    assign next_acc = acc + ACC_W'(PHASE_STEPS);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending <= '0;
            busy <= 1'b0;
            acc <= '0;
            start <= '0;
        end else if (busy && next_acc >= target) begin
            start <= pending; // [RULE14]
            pending <= trig;
            busy <= |trig;
            acc <= '0;
        end else begin
            start <= '0;
            pending <= pending | trig;
            busy <= busy | (|trig);
            if (busy) begin
                acc <= next_acc;
            end
        end
    end

endmodule : adc_phase_delay

`default_nettype wire

// >>> hdl/adc_ctrl.sv
/*
 * Converter control top: averaging, phase delay, twelve interrupt
 * sources with raw and masked views, and the register port.
 * Assumes a one-cycle strobe register master and synchronous inputs.
 */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl (
    input wire logic clk, // Module clock, 10 MHz
    input wire logic rst_n, // Sync reset, low
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] reg_addr, // Word index
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire logic conv_valid, // Raw conversion valid
    input wire logic [adc_ctrl_pkg::DATA_W-1:0] conv_data, // Raw data
    input wire logic [adc_ctrl_pkg::SEQ_W-1:0] conv_seq, // Sequencer
    input wire logic conv_last, // Last step of sequence
    input wire logic [adc_ctrl_pkg::SEQ_N-1:0] dma_done, // DMA events
    input wire logic [adc_ctrl_pkg::SEQ_N-1:0] compare_hit, // Compare
    input wire logic [adc_ctrl_pkg::SEQ_N-1:0] trig_in, // Triggers
    output logic [adc_ctrl_pkg::SEQ_N-1:0] seq_start, // Delayed starts
    output logic result_valid, // FIFO push strobe
    output logic [adc_ctrl_pkg::DATA_W-1:0] result_data, // FIFO entry
    output logic [adc_ctrl_pkg::SEQ_W-1:0] result_seq, // Target FIFO
    output logic result_last, // Entry ends sequence
    output logic irq // Level interrupt
);
    import adc_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations

    logic [FACTOR_W-1:0] averaging_factor;
    logic [PHASE_W-1:0] phase;
    logic status_view_select;
    logic [SRC_N-1:0] int_enable;
    logic [SRC_N-1:0] raw_status;
    logic [SRC_N-1:0] masked_status;
    logic [SRC_N-1:0] next_raw_status;
    logic [SRC_N-1:0] events;
    logic [SRC_N-1:0] clear_bits;
    logic [SRC_N-1:0] enable_rise;
    logic [SRC_N-1:0] status_view;
    logic [SEQ_N-1:0] done_evt;
    logic [SEQ_N-1:0] seq_raw_any;
    logic [SEQ_N-1:0] seq_masked_any;
    logic [CNT16_W-1:0] result_cnt [SEQ_N];
    logic wr_ctrl;
    logic wr_enable;
    logic wr_clear;
    logic rd_status;

    sample_if raw_if ();
    sample_if avg_if ();

    ////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0] r);
        hit = (a == r);
    endfunction : hit

    assign wr_ctrl = reg_wr && hit(reg_addr, REG_CTRL);
    assign wr_enable = reg_wr && hit(reg_addr, REG_INT_ENABLE);
    assign wr_clear = reg_wr && hit(reg_addr, REG_INT_CLEAR);
    assign rd_status = reg_rd && hit(reg_addr, REG_INT_STATUS);

    ////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            averaging_factor <= FACTOR_RST;
            phase <= PHASE_RST;
            status_view_select <= 1'b0;
        end else if (wr_ctrl) begin
            averaging_factor <= reg_wdata[FACTOR_LSB +: FACTOR_W]; // [RULE3]
            phase <= reg_wdata[PHASE_LSB +: PHASE_W]; // [RULE14]
            status_view_select <= reg_wdata[VIEW_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data path

    assign raw_if.valid = conv_valid;
    assign raw_if.data = conv_data;
    assign raw_if.seq = conv_seq;
    assign raw_if.last = conv_last;

    adc_averager u_avg (
        .clk(clk),
        .rst_n(rst_n),
        .factor(averaging_factor),
        .raw(raw_if),
        .avg(avg_if)
    );

    assign result_valid = avg_if.valid; // [RULE4]
    assign result_data = avg_if.data;
    assign result_seq = avg_if.seq;
    assign result_last = avg_if.last;

    adc_phase_delay u_phase (
        .clk(clk),
        .rst_n(rst_n),
        .phase(phase),
        .trig(trig_in),
        .start(seq_start)
    );

    ////////////////////////////////////////////////////////////////////
    // Delivered result counters, one per sequencer

    genvar s;
    generate
        for (s = 0; s < SEQ_N; s++) begin : g_seq
            assign done_evt[s] = avg_if.valid && avg_if.last &&
                                 (avg_if.seq == SEQ_W'(s)); // [RULE15]
            assign seq_raw_any[s] = raw_status[DONE_LSB + s] |
                                    raw_status[DMA_LSB + s] |
                                    raw_status[CMP_LSB + s];
            assign seq_masked_any[s] = masked_status[DONE_LSB + s] |
                                       masked_status[DMA_LSB + s] |
                                       masked_status[CMP_LSB + s];

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    result_cnt[s] <= '0;
                end else if (avg_if.valid &&
                             avg_if.seq == SEQ_W'(s)) begin
                    result_cnt[s] <= result_cnt[s] + 16'h0001; // [RULE5]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Interrupt sources

    assign events = {compare_hit, dma_done, done_evt}; // [RULE9]
    assign masked_status = raw_status & int_enable; // [RULE8]
    assign enable_rise = reg_wdata[SRC_N-1:0] & ~int_enable;
    assign status_view = status_view_select ? masked_status
                                            : raw_status; // [RULE12]

    always_comb begin
        clear_bits = '0;
        if (wr_clear) begin
            clear_bits = clear_bits | reg_wdata[SRC_N-1:0]; // [RULE6]
        end
        if (wr_enable) begin
            clear_bits = clear_bits | enable_rise; // [RULE10]
        end
        if (rd_status) begin
            clear_bits = clear_bits | status_view;
        end
        // A new event wins over a clear in the same cycle
        next_raw_status = (raw_status & ~clear_bits) | events;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            raw_status <= '0;
        end else begin
            raw_status <= next_raw_status; // [RULE7] [RULE15]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_enable <= ENABLE_RST;
        end else if (wr_enable) begin
            int_enable <= reg_wdata[SRC_N-1:0]; // [RULE8]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |masked_status; // [RULE16] [RULE7]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: begin
                    reg_rdata <= {23'h000000, status_view_select,
                                  phase, 1'b0,
                                  averaging_factor}; // [RULE13]
                end
                REG_INT_ENABLE: begin
                    reg_rdata <= {20'h00000, int_enable};
                end
                REG_INT_STATUS: begin
                    reg_rdata <= {20'h00000, status_view}; // [RULE12]
                end
                REG_INT_RAW: begin
                    reg_rdata <= {20'h00000, raw_status};
                end
                REG_INT_MASKED: begin
                    reg_rdata <= {20'h00000, masked_status};
                end
                REG_SEQ_STATUS: begin
                    reg_rdata <= {24'h000000, seq_masked_any,
                                  seq_raw_any}; // [RULE11]
                end
                REG_RESULT_CNT0: begin
                    reg_rdata <= {16'h0000, result_cnt[0]};
                end
                REG_RESULT_CNT0 + 4'h1: begin
                    reg_rdata <= {16'h0000, result_cnt[1]};
                end
                REG_RESULT_CNT0 + 4'h2: begin
                    reg_rdata <= {16'h0000, result_cnt[2]};
                end
                REG_RESULT_CNT0 + 4'h3: begin
                    reg_rdata <= {16'h0000, result_cnt[3]};
                end
                default: begin
                    reg_rdata <= 32'h00000000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule : adc_ctrl

`default_nettype wire

// >>> testbench/adc_ctrl_chk.sv
/*
 * Port checker for the converter control top.
 * Assumes single clock clk, sync active-low reset rst_n.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_chk (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] reg_addr, // Word index
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic conv_valid, // Conversion valid
    input wire logic [adc_ctrl_pkg::SEQ_N-1:0] dma_done, // DMA events
    input wire logic [adc_ctrl_pkg::SEQ_N-1:0] compare_hit, // Compare
    input wire logic [adc_ctrl_pkg::SEQ_N-1:0] trig_in, // Triggers
    input wire logic [adc_ctrl_pkg::SEQ_N-1:0] seq_start, // Starts
    input wire logic result_valid, // FIFO push
    input wire logic irq // Interrupt
);
    import adc_ctrl_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////
    sequence masked_read_s;
        reg_rd && reg_addr == REG_INT_MASKED ##1 1'b1;
    endsequence
    // No source event and no write, with irq still low a cycle later
    sequence irq_quiet_s;
        !(reg_wr || result_valid || dma_done != 4'h0 ||
          compare_hit != 4'h0) ##1 !irq;
    endsequence

    masked_view_a: assert property (
        masked_read_s |-> irq == (reg_rdata[11:0] != 12'h000))
        else $error("irq disagrees with masked status");
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    rdata_upper_a: assert property (
        $past(reg_rd) |-> reg_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    start_delay_a: assert property (
        trig_in != 4'h0 |-> ##[2:39] seq_start != 4'h0)
        else $error("start missing after trigger");
    start_pulse_a: assert property (
        seq_start != 4'h0 |=> seq_start == 4'h0)
        else $error("start longer than one cycle");
    result_cause_a: assert property (
        result_valid |-> $past(conv_valid))
        else $error("result without conversion");
    irq_fall_a: assert property (
        $fell(irq) |-> $past(reg_wr || reg_rd, 2))
        else $error("irq dropped without access");
    irq_rise_a: assert property (
        irq_quiet_s |=> !irq)
        else $error("irq rose without cause");
endmodule : adc_ctrl_chk

bind adc_ctrl adc_ctrl_chk chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_rdata, .conv_valid, .dma_done, .compare_hit, .trig_in, .seq_start,
    .result_valid, .irq);

`default_nettype wire

// >>> testbench/cpu_model.sv
/*
 * Processor side register master for the converter control block.
 * Assumes read data stands only in the cycle after the read strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module cpu_model (
    input wire logic clk, // Clock
    output logic [adc_ctrl_pkg::ADDR_W-1:0] reg_addr, // Word index
    output logic [31:0] reg_wdata, // Write data
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata // Read data
);
    import adc_ctrl_pkg::*;
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : cpu_model

`default_nettype wire

// >>> testbench/adc_ctrl_tb_top.sv
/*
 * Self-checking bench for the converter control top.
 * Assumes cpu_model for register access; bench drives event inputs.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_tb_top;
    import adc_ctrl_pkg::*;
    logic clk, rst_n, conv_valid, conv_last, reg_wr, reg_rd, irq;
    logic result_valid, result_last, last_flag;
    logic [11:0] conv_data, result_data, last_data;
    logic [1:0] conv_seq, result_seq, last_seq;
    logic [3:0] dma_done, compare_hit, trig_in, seq_start, reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdv;
    int n_errors, comparisons, n_results, sum, cnt, expc, sh;
    int pv[3] = '{0, 8, 15};

    cpu_model cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    adc_ctrl uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .conv_valid(conv_valid),
        .conv_data(conv_data), .conv_seq(conv_seq), .conv_last(conv_last),
        .dma_done(dma_done), .compare_hit(compare_hit), .trig_in(trig_in),
        .seq_start(seq_start), .result_valid(result_valid),
        .result_data(result_data), .result_seq(result_seq),
        .result_last(result_last), .irq(irq));

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (result_valid === 1'b1) begin
            n_results <= n_results + 1;
            last_data <= result_data;
            last_seq <= result_seq;
            last_flag <= result_last;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        cpu.rd(a, rdv);
        check(rdv, e);
    endtask : rchk

    task automatic pulse(input logic [3:0] d, input logic [3:0] c);
        @(posedge clk);
        dma_done <= d;
        compare_hit <= c;
        @(posedge clk);
        dma_done <= 4'h0;
        compare_hit <= 4'h0;
        repeat (2) @(posedge clk);
    endtask : pulse

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    initial begin
        #(4000 * 100);
        n_errors++;
        $display("watchdog expired");
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        {n_errors, comparisons, n_results} = '0;
        {rst_n, conv_valid, conv_last, conv_data, conv_seq} = '0;
        {dma_done, compare_hit, trig_in} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rchk(REG_CTRL, 32'h0);
        rchk(REG_INT_ENABLE, 32'h0);
        rchk(REG_INT_RAW, 32'h0);
        rchk(4'h7, 32'h0);
        $display("test reset done");
        // Code 7 acts as 64x
        for (int n = 0; n <= 7; n++) begin
            sh = (n > 6) ? 6 : n;
            sum = 0;
            n_results = 0;
            cpu.wr(REG_CTRL, 32'(n));
            for (int k = 0; k < (1 << sh); k++) begin
                @(posedge clk);
                conv_valid <= 1'b1;
                conv_data <= 12'(100 + 7 * k);
                conv_seq <= 2'(n);
                conv_last <= (k == (1 << sh) - 1);
                sum += 100 + 7 * k;
            end
            @(posedge clk);
            conv_valid <= 1'b0;
            conv_data <= ~conv_data;
            repeat (3) @(posedge clk);
            check(32'(n_results), 32'h1);
            check(32'(last_data), 32'(sum >> sh));
            check(32'(last_flag), 32'h1);
            check(32'(last_seq), 32'(n % 4));
        end
        rchk(REG_RESULT_CNT0, 32'h2);
        rchk(REG_RESULT_CNT0 + 4'h3, 32'h2);
        rchk(REG_INT_RAW, 32'h00F);
        $display("test averaging done");
        cpu.wr(REG_INT_ENABLE, 32'h010);
        pulse(4'hF, 4'hF);
        rchk(REG_INT_RAW, 32'hFFF);
        rchk(REG_INT_MASKED, 32'h010);
        rchk(REG_SEQ_STATUS, 32'h01F);
        check(32'(irq), 32'h1);
        cpu.wr(REG_INT_ENABLE, 32'hFFF);
        rchk(REG_INT_RAW, 32'h010);
        cpu.wr(REG_INT_CLEAR, 32'h010);
        #1;
        check(32'(irq), 32'h1);
        @(posedge clk);
        #1;
        check(32'(irq), 32'h0);
        cpu.wr(REG_CTRL, 32'h100);
        pulse(4'h0, 4'hF);
        rchk(REG_INT_STATUS, 32'hF00);
        rchk(REG_INT_RAW, 32'h0);
        cpu.wr(REG_INT_ENABLE, 32'h0);
        pulse(4'hF, 4'h0);
        check(32'(irq), 32'h0);
        rchk(REG_INT_RAW, 32'h0F0);
        $display("test interrupts done");
        foreach (pv[i]) begin
            expc = (pv[i] == 0) ? 2 : 1 + (pv[i] * 40 + 15) / 16;
            cpu.wr(REG_CTRL, 32'(pv[i] << 4));
            rchk(REG_CTRL, 32'(pv[i] << 4));
            @(posedge clk);
            trig_in <= 4'hF;
            cnt = 0;
            do begin
                @(posedge clk);
                trig_in <= 4'h0;
                cnt++;
                #1;
            end while (seq_start === 4'h0 && cnt < 60);
            check(32'(cnt), 32'(expc));
            check(32'(seq_start), 32'hF);
        end
        $display("test phase done");
        complete_run();
    end
endmodule : adc_ctrl_tb_top

`default_nettype wire
